//--- design/bfsf_map.svh
`ifndef BFSF_MAP_SVH
`define BFSF_MAP_SVH

// Bit positions of the flags within the fault status word
`define BFSF_BIT_UNSTACK  11
`define BFSF_BIT_DEFERRED 10
`define BFSF_BIT_EXACT    9

// Index of each flag within the local flag vector
`define BFSF_IDX_EXACT    0
`define BFSF_IDX_DEFERRED 1
`define BFSF_IDX_UNSTACK  2

`define BFSF_NFLAGS       3
`define BFSF_FLAG_RST     3'h0
`define BFSF_ADDR_RST     32'h0000_0000

`endif

//--- design/bfsf_pkg.sv
`include "bfsf_map.svh"

package bfsf_pkg;
  typedef logic [`BFSF_NFLAGS-1:0] bfsf_flags_t;
  typedef logic [31:0]             bfsf_word_t;
  typedef logic [7:0]              bfsf_prio_t;
endpackage

//--- design/bfsf_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "bfsf_map.svh"

interface bfsf_flag_if;
  bfsf_pkg::bfsf_flags_t set;
  bfsf_pkg::bfsf_flags_t clr;
  bfsf_pkg::bfsf_flags_t q;
  modport ctl  (output set, output clr, input q);
  modport bank (input set, input clr, output q);
endinterface

`default_nettype wire

//--- design/bfsf_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "bfsf_map.svh"

module bfsf_flag_bank (
  input  wire logic  clk_sys_i,
  input  wire logic  sys_rst_i,
  bfsf_flag_if.bank  flg
);

  bfsf_pkg::bfsf_flags_t q;
  // A net, since each bit has its own driver in the loop below
  wire   bfsf_pkg::bfsf_flags_t next_q;

  genvar g;
  generate
    for (g = 0; g < `BFSF_NFLAGS; g = g + 1)
    begin : g_flag
      // Set beats a same-cycle clear so no fault event is lost
      assign next_q[g] = flg.set[g] | (q[g] & ~flg.clr[g]); // RL9 RL11
    end
  endgenerate

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      q <= `BFSF_FLAG_RST; // RL11
    else
      q <= next_q;
  end

  assign flg.q = q;

endmodule // bfsf_flag_bank

`default_nettype wire

//--- design/bfsf_top.sv
// Notes on behaviour
// RL1 - Unstack bus fault sets flag bit 11
// RL2 - Unstack fault chains straight into handler
// RL3 - Unstack fault: SP kept, no save, no address
// RL4 - Deferred data error sets flag bit 10
// RL5 - Deferred error captures no fault address
// RL6 - Deferred error waits while running priority higher
// RL7 - Exact fault before entry keeps deferred flag
// RL8 - Exact data error flag bit 9
// RL9 - Software clears a flag by writing one
// RL10 - Exact error loads address, stacks faulting PC
// RL11 - Flags reset to zero, sticky until cleared
`timescale 1ns/1ps
`default_nettype none
`include "bfsf_map.svh"

module bfsf_top (
  input  wire logic                clk_sys_i,
  input  wire logic                sys_rst_i,
  input  wire logic                unstack_fault_i,
  input  wire logic                deferred_err_i,
  input  wire logic                exact_err_i,
  input  wire bfsf_pkg::bfsf_word_t exact_addr_i,
  input  wire bfsf_pkg::bfsf_word_t exact_pc_i,
  input  wire bfsf_pkg::bfsf_prio_t run_prio_i,
  input  wire bfsf_pkg::bfsf_prio_t bus_fault_prio_i,
  input  wire logic                sw_wr_i,
  input  wire bfsf_pkg::bfsf_word_t sw_wdata_i,
  output logic                     unstack_fault_flag_o,
  output logic                     deferred_data_error_flag_o,
  output logic                     exact_data_error_flag_o,
  output bfsf_pkg::bfsf_word_t     bus_fault_location_reg_o,
  output bfsf_pkg::bfsf_word_t     stacked_ret_addr_o,
  output logic                     save_req_o,
  output logic                     chain_req_o,
  output logic                     fault_req_o,
  output logic                     deferred_pending_o
);

  bfsf_flag_if flg ();

  bfsf_flag_bank u_bank (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .flg       (flg.bank)
  );

  // Write-one-to-clear decode, shared by all three flags
  function automatic logic clr_hit(
    input logic                 wr,
    input bfsf_pkg::bfsf_word_t data,
    input int                   pos
  );
    clr_hit = wr & data[pos];
  endfunction

  // Event and clear strobes, one bit per flag
  wire   bfsf_pkg::bfsf_flags_t set_vec;
  wire   bfsf_pkg::bfsf_flags_t clr_vec;

  // Each flag is set by its own event only, so an exact error leaves
  // a deferred flag already standing untouched
  assign set_vec[`BFSF_IDX_UNSTACK]  = unstack_fault_i; // RL1
  assign set_vec[`BFSF_IDX_DEFERRED] = deferred_err_i;  // RL4
  assign set_vec[`BFSF_IDX_EXACT]    = exact_err_i;     // RL8 RL7

  assign clr_vec[`BFSF_IDX_UNSTACK]  =
    clr_hit(sw_wr_i, sw_wdata_i, `BFSF_BIT_UNSTACK);  // RL9
  assign clr_vec[`BFSF_IDX_DEFERRED] =
    clr_hit(sw_wr_i, sw_wdata_i, `BFSF_BIT_DEFERRED); // RL9
  assign clr_vec[`BFSF_IDX_EXACT]    =
    clr_hit(sw_wr_i, sw_wdata_i, `BFSF_BIT_EXACT);    // RL9

  // Whole words go to the bank, so each interface signal has one driver
  assign flg.set = set_vec;
  assign flg.clr = clr_vec;

  // Numerically lower priority value means more urgent
  wire   run_outranks;
  wire   deferred_seen;
  wire   deferred_now;
  wire   next_pending;
  logic  pending;

  assign run_outranks  = run_prio_i < bus_fault_prio_i;
  assign deferred_seen = deferred_err_i | pending;
  // Asynchronous error waits out every more urgent context
  assign deferred_now  = deferred_seen & ~run_outranks; // RL6
  assign next_pending  = deferred_seen & run_outranks;  // RL6

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      pending <= 1'h0;
    end
    else
    begin
      pending <= next_pending;
    end
  end

  // Request strobes for the exception sequencer
  wire   next_chain;
  wire   next_save;
  wire   next_fault;

  // Unstack chains without a new save, so the old frame and SP stay
  assign next_chain = unstack_fault_i;                 // RL2 RL3
  assign next_save  = exact_err_i & ~unstack_fault_i;  // RL3 RL10
  assign next_fault = unstack_fault_i | exact_err_i | deferred_now; // RL6

  // Only a precise error knows its address; deferred and unstack
  // faults leave the location register as it was
  wire   load_addr;
  assign load_addr = exact_err_i; // RL10 RL5 RL3

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      bus_fault_location_reg_o <= `BFSF_ADDR_RST;
    end
    else if (load_addr)
    begin
      bus_fault_location_reg_o <= exact_addr_i; // RL10 RL5 RL3
    end
  end

  // Stacked return address points back at the faulting access
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      stacked_ret_addr_o <= `BFSF_ADDR_RST;
    end
    else if (load_addr)
    begin
      stacked_ret_addr_o <= exact_pc_i; // RL10
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      chain_req_o <= 1'h0;
    end
    else
    begin
      chain_req_o <= next_chain; // RL2
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      save_req_o <= 1'h0;
    end
    else
    begin
      save_req_o <= next_save; // RL3
    end
  end

  // A deferred error reaches here only once it may be taken
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      fault_req_o <= 1'h0;
    end
    else
    begin
      fault_req_o <= next_fault; // RL6
    end
  end

  // Flag copies, registered so every output comes from a flop
  wire   unstack_q;
  wire   deferred_q;
  wire   exact_q;

  assign unstack_q  = flg.q[`BFSF_IDX_UNSTACK];
  assign deferred_q = flg.q[`BFSF_IDX_DEFERRED];
  assign exact_q    = flg.q[`BFSF_IDX_EXACT];

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      unstack_fault_flag_o <= 1'h0;
    end
    else
    begin
      unstack_fault_flag_o <= unstack_q;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      deferred_data_error_flag_o <= 1'h0;
    end
    else
    begin
      deferred_data_error_flag_o <= deferred_q;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      exact_data_error_flag_o <= 1'h0;
    end
    else
    begin
      exact_data_error_flag_o <= exact_q;
    end
  end

  // Mirror of the hold, so the sequencer can see the wait
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      deferred_pending_o <= 1'h0;
    end
    else
    begin
      deferred_pending_o <= next_pending;
    end
  end

endmodule // bfsf_top

`default_nettype wire

//--- bench/bfsf_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bfsf_checker (
  input wire logic                 clk_sys_i,
  input wire logic                 sys_rst_i,
  input wire logic                 unstack_fault_i,
  input wire logic                 deferred_err_i,
  input wire logic                 exact_err_i,
  input wire logic                 sw_wr_i,
  input wire logic                 unstack_fault_flag_o,
  input wire logic                 deferred_data_error_flag_o,
  input wire logic                 exact_data_error_flag_o,
  input wire logic                 save_req_o,
  input wire logic                 chain_req_o,
  input wire logic                 fault_req_o,
  input wire logic                 deferred_pending_o,
  input wire bfsf_pkg::bfsf_word_t exact_addr_i,
  input wire bfsf_pkg::bfsf_word_t exact_pc_i,
  input wire bfsf_pkg::bfsf_word_t sw_wdata_i,
  input wire bfsf_pkg::bfsf_word_t bus_fault_location_reg_o,
  input wire bfsf_pkg::bfsf_word_t stacked_ret_addr_o,
  input wire bfsf_pkg::bfsf_prio_t run_prio_i,
  input wire bfsf_pkg::bfsf_prio_t bus_fault_prio_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  wire logic       hi = run_prio_i < bus_fault_prio_i;
  wire logic [2:0] f  = {unstack_fault_flag_o, deferred_data_error_flag_o,
                         exact_data_error_flag_o};
  sequence s_clr;
    sw_wr_i && sw_wdata_i[11] && !unstack_fault_i ##1 !unstack_fault_i;
  endsequence
  property p_us; unstack_fault_i |-> ##2 unstack_fault_flag_o; endproperty
  a_us: assert property (p_us) else $error("unstack flag");
  property p_ch; unstack_fault_i |=> chain_req_o && !save_req_o; endproperty
  a_ch: assert property (p_ch) else $error("chain");
  property p_na; (unstack_fault_i || deferred_err_i) && !exact_err_i
    |=> $stable(bus_fault_location_reg_o); endproperty
  a_na: assert property (p_na) else $error("address load");
  property p_df; deferred_err_i |-> ##2 deferred_data_error_flag_o;
  endproperty
  a_df: assert property (p_df) else $error("deferred flag");
  property p_pd; deferred_err_i && hi |=> deferred_pending_o; endproperty
  a_pd: assert property (p_pd) else $error("pending");
  property p_rl; deferred_pending_o && !hi |=> fault_req_o; endproperty
  a_rl: assert property (p_rl) else $error("release");
  property p_ex; exact_err_i |-> ##2 exact_data_error_flag_o; endproperty
  a_ex: assert property (p_ex) else $error("exact flag");
  property p_ad; exact_err_i && !unstack_fault_i |=> save_req_o &&
    bus_fault_location_reg_o == $past(exact_addr_i) &&
    stacked_ret_addr_o == $past(exact_pc_i); endproperty
  a_ad: assert property (p_ad) else $error("address");
  property p_st; !sw_wr_i && !$past(sw_wr_i) |=> (f & $past(f)) == $past(f);
  endproperty
  a_st: assert property (p_st) else $error("sticky");
  property p_cl; s_clr |=> !unstack_fault_flag_o; endproperty
  a_cl: assert property (p_cl) else $error("clear");
endmodule // bfsf_checker
bind bfsf_top bfsf_checker bfsf_checker_inst (.*);
`default_nettype wire

//--- bench/bfsf_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module bfsf_top_tb;
  logic clk_sys_i = 0, sys_rst_i = 1, uf = 0, de = 0, ee = 0, wr = 0;
  logic uo, dfo, xo, sv, ch, fr, pd;
  bfsf_pkg::bfsf_word_t ad = 0, wd = 0, loc, ret;
  bfsf_pkg::bfsf_prio_t rp = 8'h08, bp = 8'h04;
  int failures = 0, n_checks = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  bfsf_top bfsf_top_inst (.clk_sys_i, .sys_rst_i, .unstack_fault_i(uf),
    .deferred_err_i(de), .exact_err_i(ee), .exact_addr_i(ad),
    .exact_pc_i(~ad), .run_prio_i(rp), .bus_fault_prio_i(bp), .sw_wr_i(wr),
    .sw_wdata_i(wd), .unstack_fault_flag_o(uo),
    .deferred_data_error_flag_o(dfo), .exact_data_error_flag_o(xo),
    .bus_fault_location_reg_o(loc), .stacked_ret_addr_o(ret),
    .save_req_o(sv), .chain_req_o(ch), .fault_req_o(fr),
    .deferred_pending_o(pd));
  task finish_test;
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Pulse the given events for one cycle, then step past the first answer edge
  task ev(input logic u, d, x, input bfsf_pkg::bfsf_word_t a);
    @(negedge clk_sys_i); uf = u; de = d; ee = x; ad = a;
    @(negedge clk_sys_i); uf = 0; de = 0; ee = 0;
  endtask
  task clr(input logic [2:0] b);
    @(negedge clk_sys_i); wr = 1; wd = {20'h0, b, 9'h0};
    @(negedge clk_sys_i); wr = 0;
    repeat (2) @(negedge clk_sys_i);
  endtask
  task t_exact;
    ev(0, 0, 1, 32'h1234_5678);
    `CHK("loc", 32'h1234_5678, loc)
    `CHK("ret", ~32'h1234_5678, ret)
    `CHK("save", 1'b1, sv)
    @(negedge clk_sys_i); `CHK("exact", 1'b1, xo)
  endtask
  task t_unstack;
    ev(1, 0, 0, 32'hDEAD_BEEF);
    `CHK("chain", 1'b1, ch)
    `CHK("save0", 1'b0, sv)
    `CHK("loc_u", 32'h1234_5678, loc)
    @(negedge clk_sys_i); `CHK("unstack", 1'b1, uo)
  endtask
  task t_defer;
    rp = 8'h01;
    ev(0, 1, 0, 32'h0);
    `CHK("pend", 1'b1, pd)
    `CHK("freq0", 1'b0, fr)
    @(negedge clk_sys_i); `CHK("defer", 1'b1, dfo)
    `CHK("loc_d", 32'h1234_5678, loc)
    clr(3'b001); `CHK("xclr", 2'b10, {dfo, xo})
    ev(0, 0, 1, 32'hA5A5_0000);
    @(negedge clk_sys_i); `CHK("both", 2'b11, {dfo, xo})
    rp = 8'h08;
    for (int i = 0; i < 4 && fr !== 1'b1; i++) @(negedge clk_sys_i);
    `CHK("release", 1'b1, fr)
  endtask
  task t_clear;
    clr(3'b000); `CHK("w0", 3'b111, {uo, dfo, xo})
    clr(3'b010); `CHK("w10", 3'b101, {uo, dfo, xo})
    clr(3'b101); `CHK("w11_9", 3'b000, {uo, dfo, xo})
  endtask
  // Reset in mid-run must drop every flag and the captured address
  task t_reset;
    ev(1, 1, 1, 32'h0F0F_0F0F);
    sys_rst_i = 1;
    @(negedge clk_sys_i); sys_rst_i = 0;
    `CHK("rst2", 4'h0, {uo, dfo, xo, pd})
    `CHK("rst2_loc", 32'h0, loc)
    @(negedge clk_sys_i); `CHK("rst2_hold", 3'b000, {uo, dfo, xo})
  endtask
  initial begin
    #20000; failures++; finish_test;
  end
  initial begin
    repeat (4) @(negedge clk_sys_i);
    sys_rst_i = 0;
    `CHK("rst", 3'b000, {uo, dfo, xo})
    t_exact; t_unstack; t_defer; t_clear; t_reset;
    finish_test;
  end
endmodule // bfsf_top_tb
`default_nettype wire
